// *** hw/dio_trig_pkg.sv ***
// Constants and carrier types for the digital port and trigger switch loader.
// Assumes a simple synchronous host register port with byte-granular offsets.
package dio_trig_pkg;
   localparam int ADDR_W = 20;
   localparam logic [19:0] DIGITAL_LINE_OFS = 20'h00038;
   localparam logic [19:0] ROUTING_SHIFT_OFS = 20'hC0000;
   localparam logic [19:0] ROUTING_STROBE_OFS = 20'hC0004;
   localparam logic [19:0] CFG_ROM_FIRST_OFS = 20'hF8000;
   localparam logic [19:0] CFG_ROM_LAST_OFS = 20'hFFFFC;
   localparam int CFG_ROM_BYTES = 8192;
   localparam int ROUTING_BITS = 56;
   localparam int UPPER_NIBBLE_LSB = 4;
   localparam int LOWER_NIBBLE_LSB = 0;
   localparam int SERIAL_BIT_POS = 0;
   localparam logic [7:0] OUT_PATTERN_RESET = 8'h00;
   localparam logic [55:0] ROUTING_RESET = 56'h00000000000000;
   localparam logic [1:0] DRIVE_EN_RESET = 2'h0;
   localparam logic [7:0] LINE_SYNC_RESET = 8'h00;
   localparam logic [3:0] LINE_OUT_RESET = 4'h0;
   localparam logic [3:0] LINE_OE_N_RESET = 4'hF;
   localparam logic [15:0] READ_DATA_RESET = 16'h0000;
   localparam logic READ_VALID_RESET = 1'b0;

   typedef struct packed {
      logic        rd;
      logic        wr;
      logic [19:0] addr;
      logic [15:0] wdata;
   } host_req_t;

   typedef struct packed {
      logic [3:0] upper;
      logic [3:0] lower;
   } port_pair_t;
endpackage

// *** hw/routing_loader.sv ***
// Serial routing pattern shifter and control register for the trigger switch.
// Assumes shift and strobe pulses come from register decode on the same clock.
module routing_loader
   import dio_trig_pkg::*;
#(
   parameter int BITS = ROUTING_BITS
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Load controls
   input wire logic shift,
   input wire logic routing_serial_bit,
   input wire logic strobe,
   // Pattern
   output logic [BITS-1:0] chain,
   output logic [BITS-1:0] control
);
   // First written bit walks toward the MSB end
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         chain <= BITS'(ROUTING_RESET);
      end else if (shift) begin
         chain <= {chain[BITS-2:0], routing_serial_bit};
      end
   end

   // Control only moves on strobe; all-zero means every pin is an input
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         control <= BITS'(ROUTING_RESET);
      end else if (strobe) begin
         control <= chain;
      end
   end
endmodule

// *** hw/dio_port_and_trigger_switch_loader.sv ***
// Host register logic for the eight digital lines and trigger switch loader.
// Assumes a one-cycle host read/write strobe on CORE_CLK and pads off chip.
module dio_port_and_trigger_switch_loader
   import dio_trig_pkg::*;
#(
   parameter int ROM_DEPTH = CFG_ROM_BYTES
) (
   // Clock and reset
   input wire logic CORE_CLK,
   input wire logic RST_N,
   // Host register port
   input wire logic HOST_RD,
   input wire logic HOST_WR,
   input wire logic [19:0] HOST_ADDR,
   input wire logic [15:0] HOST_WDATA,
   output logic [15:0] HOST_RDATA,
   output logic HOST_RVALID,
   // Drive enables from the board command register
   input wire logic UPPER_PORT_DRIVE_ENABLE,
   input wire logic LOWER_PORT_DRIVE_ENABLE,
   // Digital lines: input, output, active-low output enable
   input wire logic [3:0] UPPER_PORT_LINES_IN,
   input wire logic [3:0] LOWER_PORT_LINES_IN,
   output logic [3:0] UPPER_PORT_LINES_OUT,
   output logic [3:0] LOWER_PORT_LINES_OUT,
   output logic [3:0] UPPER_PORT_LINES_OE_N,
   output logic [3:0] LOWER_PORT_LINES_OE_N,
   // Trigger switch control pattern
   output logic [ROUTING_BITS-1:0] TRIGGER_BUS_ROUTING
);
   host_req_t req;
   port_pair_t out_pattern;
   port_pair_t line_meta;
   port_pair_t line_sync;
   logic upper_en_meta;
   logic lower_en_meta;
   logic upper_port_drive_enable;
   logic lower_port_drive_enable;
   logic [3:0] upper_port_in_bits;
   logic [3:0] lower_port_in_bits;
   logic [3:0] upper_port_out_bits;
   logic [3:0] lower_port_out_bits;
   logic [7:0] rom [ROM_DEPTH];
   logic [ROUTING_BITS-1:0] control;
   logic digital_wr;
   logic digital_rd;
   logic shift_wr;
   logic strobe_wr;
   logic rom_hit;
   logic [12:0] rom_index;

   // Exact match only, so no alias offset can move the switch
   function automatic logic hit(input logic [19:0] a, input logic [19:0] ofs);
      return a == ofs;
   endfunction

   // Whole window, last byte at the top word
   function automatic logic in_rom(input logic [19:0] a);
      return a >= CFG_ROM_FIRST_OFS && a <= CFG_ROM_LAST_OFS;
   endfunction

   // One ROM byte per four offsets; low two address bits dropped
   function automatic logic [12:0] rom_slot(input logic [19:0] a);
      return a[14:2];
   endfunction

   // Reads are byte wide; bits 15-8 always return zero
   function automatic logic [15:0] byte_word(input logic [7:0] b);
      return {8'h00, b};
   endfunction

   // Active-low enable spread over a whole nibble
   function automatic logic [3:0] nibble_oe_n(input logic en);
      return {4{~en}};
   endfunction

   assign req = '{rd: HOST_RD, wr: HOST_WR, addr: HOST_ADDR, wdata: HOST_WDATA};
   assign digital_wr = req.wr && hit(req.addr, DIGITAL_LINE_OFS);
   assign digital_rd = req.rd && hit(req.addr, DIGITAL_LINE_OFS);
   assign shift_wr = req.wr && hit(req.addr, ROUTING_SHIFT_OFS);
   assign strobe_wr = req.wr && hit(req.addr, ROUTING_STROBE_OFS);
   assign rom_hit = req.rd && in_rom(req.addr);
   assign rom_index = rom_slot(req.addr);

   // Named views of the synchronised lines and pattern nibbles
   assign upper_port_in_bits = line_sync.upper;
   assign lower_port_in_bits = line_sync.lower;
   assign upper_port_out_bits = out_pattern.upper;
   assign lower_port_out_bits = out_pattern.lower;

   // Contents are zeroed at start of simulation, never loaded by the host
   initial begin
      for (int i = 0; i < ROM_DEPTH; i++) begin
         rom[i] = 8'h00;
      end
   end

   // Pins cross in from outside, two flops each
   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         line_meta <= LINE_SYNC_RESET;
         line_sync <= LINE_SYNC_RESET;
      end else begin
         line_meta <= '{upper: UPPER_PORT_LINES_IN, lower: LOWER_PORT_LINES_IN};
         line_sync <= line_meta;
      end
   end

   // Enables come from another register block, so they are synchronised too
   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         upper_en_meta <= DRIVE_EN_RESET[1];
         upper_port_drive_enable <= DRIVE_EN_RESET[1];
      end else begin
         upper_en_meta <= UPPER_PORT_DRIVE_ENABLE;
         upper_port_drive_enable <= upper_en_meta;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         lower_en_meta <= DRIVE_EN_RESET[0];
         lower_port_drive_enable <= DRIVE_EN_RESET[0];
      end else begin
         lower_en_meta <= LOWER_PORT_DRIVE_ENABLE;
         lower_port_drive_enable <= lower_en_meta;
      end
   end

   // Whole byte replaced on each write; no read-back path exists
   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         out_pattern <= OUT_PATTERN_RESET;
      end else if (digital_wr) begin
         out_pattern <= req.wdata[7:0];
      end
   end

   // Shift chain and control register live in the loader
   routing_loader #(
      .BITS(ROUTING_BITS)
   ) loader (
      .clk(CORE_CLK),
      .rst_n(RST_N),
      .shift(shift_wr),
      .routing_serial_bit(req.wdata[SERIAL_BIT_POS]),
      .strobe(strobe_wr),
      .chain(),
      .control(control)
   );

   // Registered copy keeps decode glitches off the switch
   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         TRIGGER_BUS_ROUTING <= ROUTING_RESET;
      end else begin
         TRIGGER_BUS_ROUTING <= control;
      end
   end

   // Drive value follows the pattern while disabled; only the enable gates the pad
   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         UPPER_PORT_LINES_OUT <= LINE_OUT_RESET;
         UPPER_PORT_LINES_OE_N <= LINE_OE_N_RESET;
      end else begin
         UPPER_PORT_LINES_OUT <= upper_port_out_bits;
         UPPER_PORT_LINES_OE_N <= nibble_oe_n(upper_port_drive_enable);
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         LOWER_PORT_LINES_OUT <= LINE_OUT_RESET;
         LOWER_PORT_LINES_OE_N <= LINE_OE_N_RESET;
      end else begin
         LOWER_PORT_LINES_OUT <= lower_port_out_bits;
         LOWER_PORT_LINES_OE_N <= nibble_oe_n(lower_port_drive_enable);
      end
   end

   // Every read is answered one cycle later, whatever the offset
   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         HOST_RVALID <= READ_VALID_RESET;
      end else begin
         HOST_RVALID <= req.rd;
      end
   end

   // Read mux; unmapped and write-only offsets read zero
   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         HOST_RDATA <= READ_DATA_RESET;
      end else if (digital_rd) begin
         HOST_RDATA <= byte_word({upper_port_in_bits, lower_port_in_bits});
      end else if (rom_hit) begin
         HOST_RDATA <= byte_word(rom[rom_index]);
      end else begin
         HOST_RDATA <= READ_DATA_RESET;
      end
   end
endmodule

// *** dv/dio_port_chk_assertions.sv ***
// Port and timing checks for the digital port and trigger switch loader.
// Assumes it is bound into the top module and sees only its ports.
module dio_port_chk
   import dio_trig_pkg::*;
#(parameter int ROM_DEPTH = CFG_ROM_BYTES) (
   // Clock, reset and host port
   input wire logic CORE_CLK,
   input wire logic RST_N,
   input wire logic HOST_RD,
   input wire logic HOST_WR,
   input wire logic HOST_RVALID,
   input wire logic [19:0] HOST_ADDR,
   input wire logic [15:0] HOST_WDATA,
   input wire logic [15:0] HOST_RDATA,
   // Line and switch side
   input wire logic UPPER_PORT_DRIVE_ENABLE,
   input wire logic LOWER_PORT_DRIVE_ENABLE,
   input wire logic [3:0] UPPER_PORT_LINES_OUT,
   input wire logic [3:0] LOWER_PORT_LINES_OUT,
   input wire logic [3:0] UPPER_PORT_LINES_OE_N,
   input wire logic [3:0] LOWER_PORT_LINES_OE_N,
   input wire logic [ROUTING_BITS-1:0] TRIGGER_BUS_ROUTING
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (!RST_N);
   wire logic strobe_wr = HOST_WR && HOST_ADDR == ROUTING_STROBE_OFS;
   wire logic out_wr = HOST_WR && HOST_ADDR == DIGITAL_LINE_OFS;
   a_read_answer: assert property (HOST_RD |=> HOST_RVALID)
      else $error("Read got no answer");
   a_high_bits_zero: assert property (HOST_RVALID |-> HOST_RDATA[15:8] == 8'h00)
      else $error("Read upper byte not zero");
   a_shift_reads_zero: assert property (HOST_RD && HOST_ADDR == ROUTING_SHIFT_OFS
      |=> HOST_RDATA == 16'h0000)
      else $error("Write-only offset read back");
   a_out_pattern: assert property (out_wr |-> ##2
      {UPPER_PORT_LINES_OUT, LOWER_PORT_LINES_OUT} == $past(HOST_WDATA[7:0], 2))
      else $error("Line pattern not taken");
   a_upper_off: assert property (!UPPER_PORT_DRIVE_ENABLE [*4]
      |-> UPPER_PORT_LINES_OE_N == 4'hF)
      else $error("Upper lines driven while disabled");
   a_lower_on: assert property (LOWER_PORT_DRIVE_ENABLE [*4]
      |-> LOWER_PORT_LINES_OE_N == 4'h0)
      else $error("Lower lines not driven while enabled");
   a_route_on_strobe: assert property (!$stable(TRIGGER_BUS_ROUTING) |-> $past(strobe_wr, 2))
      else $error("Routing changed without strobe");
   a_reset_release: assert property ($rose(RST_N) |-> UPPER_PORT_LINES_OE_N == 4'hF
      && LOWER_PORT_LINES_OE_N == 4'hF)
      else $error("Lines driven out of reset");
   cover property (strobe_wr);
   cover property (out_wr);
   cover property (HOST_RVALID && HOST_RDATA != 16'h0000);
endmodule
bind dio_port_and_trigger_switch_loader dio_port_chk #(.ROM_DEPTH(ROM_DEPTH)) chk_u (.*);

// *** dv/dio_pin_model.sv ***
// Board-side model of four lines: driven level, else the idle level.
// Assumes the bench sets the idle level to differ from the drive value.
module dio_pin_model (
   // Design side
   input wire logic [3:0] drive,
   input wire logic [3:0] oe_n,
   // Board side
   input wire logic [3:0] idle,
   output logic [3:0] level
);
   timeunit 1ns;
   timeprecision 100ps;
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         level[i] = (oe_n[i] === 1'b0) ? drive[i] : idle[i];
      end
   end
endmodule

// *** dv/dio_port_and_trigger_switch_loader_tb_top.sv ***
// Register-call bench for the digital port and trigger switch loader.
// Assumes the pin model closes the line loop and ROM contents are zero.
module dio_port_and_trigger_switch_loader_tb_top import dio_trig_pkg::*;;
   timeunit 1ns;
   timeprecision 100ps;
   logic CORE_CLK = 1'b0, RST_N = 1'b0, HOST_RD = 1'b0, HOST_WR = 1'b0, HOST_RVALID;
   logic UPPER_PORT_DRIVE_ENABLE = 1'b0, LOWER_PORT_DRIVE_ENABLE = 1'b0;
   logic [19:0] HOST_ADDR = 20'h00000;
   logic [15:0] HOST_WDATA = 16'h0000, HOST_RDATA;
   logic [3:0] UPPER_PORT_LINES_IN, LOWER_PORT_LINES_IN, UPPER_PORT_LINES_OUT;
   logic [3:0] LOWER_PORT_LINES_OUT, UPPER_PORT_LINES_OE_N, LOWER_PORT_LINES_OE_N;
   logic [ROUTING_BITS-1:0] TRIGGER_BUS_ROUTING;
   logic [7:0] shadow;
   logic [19:0] zero_ofs [4] = '{ROUTING_SHIFT_OFS, ROUTING_STROBE_OFS, 20'h0003C, CFG_ROM_FIRST_OFS};
   localparam logic [55:0] PAT = 56'h8D3C5A0F96E1B7;
   int fail_count = 0, samples_checked = 0;
   always #2.5 CORE_CLK = ~CORE_CLK;
   dio_port_and_trigger_switch_loader dut_u (.*);
   dio_pin_model upper_u (.drive(UPPER_PORT_LINES_OUT), .oe_n(UPPER_PORT_LINES_OE_N),
      .idle(4'h3), .level(UPPER_PORT_LINES_IN));
   dio_pin_model lower_u (.drive(LOWER_PORT_LINES_OUT), .oe_n(LOWER_PORT_LINES_OE_N),
      .idle(4'hC), .level(LOWER_PORT_LINES_IN));
   task chk(input logic [55:0] seen, input logic [55:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task close_out;
      $display("Comparisons %0d, mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task step(input int n);
      repeat (n) @(posedge CORE_CLK);
      #1;
   endtask
   task wr(input logic [19:0] a, input logic [15:0] d);
      @(posedge CORE_CLK);
      HOST_WR <= 1'b1;
      HOST_ADDR <= a;
      HOST_WDATA <= d;
      @(posedge CORE_CLK);
      HOST_WR <= 1'b0;
   endtask
   task rd(input logic [19:0] a, input logic [15:0] exp);
      int n;
      @(posedge CORE_CLK);
      HOST_RD <= 1'b1;
      HOST_ADDR <= a;
      @(posedge CORE_CLK);
      HOST_RD <= 1'b0;
      #1;
      n = 0;
      while (HOST_RVALID !== 1'b1 && n < 4) begin
         step(1);
         n++;
      end
      if (n == 4) begin
         fail_count++;
         close_out;
      end else begin
         chk(HOST_RDATA, exp);
      end
   endtask
   // Bits 7-1 set on purpose: only bit 0 may enter the chain
   task sh(input logic [55:0] p);
      for (int i = 55; i >= 0; i--) wr(ROUTING_SHIFT_OFS, {15'h007F, p[i]});
   endtask
   initial begin
      repeat (16) @(posedge CORE_CLK);
      // Command setup leaves both ports undriven
      {UPPER_PORT_DRIVE_ENABLE, LOWER_PORT_DRIVE_ENABLE} <= 2'b00;
      RST_N <= 1'b1;
      step(1);
      chk({UPPER_PORT_LINES_OE_N, LOWER_PORT_LINES_OE_N}, 8'hFF);
      wr(DIGITAL_LINE_OFS, 16'hFFA5);
      step(2);
      chk({UPPER_PORT_LINES_OUT, LOWER_PORT_LINES_OUT}, 8'hA5);
      rd(DIGITAL_LINE_OFS, 16'h003C);
      @(posedge CORE_CLK);
      UPPER_PORT_DRIVE_ENABLE <= 1'b1;
      step(5);
      chk({UPPER_PORT_LINES_OE_N, LOWER_PORT_LINES_OE_N}, 8'h0F);
      rd(DIGITAL_LINE_OFS, 16'h00AC);
      shadow = 8'hA5;
      shadow[0] = 1'b0;
      wr(DIGITAL_LINE_OFS, {8'h00, shadow});
      LOWER_PORT_DRIVE_ENABLE <= 1'b1;
      step(5);
      rd(DIGITAL_LINE_OFS, 16'h00A4);
      foreach (zero_ofs[k]) rd(zero_ofs[k], 16'h0000);
      sh(PAT);
      chk(TRIGGER_BUS_ROUTING, 56'h0);
      wr(ROUTING_STROBE_OFS, 16'h00FF);
      step(2);
      chk(TRIGGER_BUS_ROUTING, PAT);
      sh(56'h0);
      chk(TRIGGER_BUS_ROUTING, PAT);
      wr(ROUTING_STROBE_OFS, 16'h0000);
      step(2);
      chk(TRIGGER_BUS_ROUTING, 56'h0);
      wr(DIGITAL_LINE_OFS, 16'h0000);
      step(2);
      chk({UPPER_PORT_LINES_OUT, LOWER_PORT_LINES_OUT}, 8'h00);
      @(posedge CORE_CLK);
      RST_N <= 1'b0;
      repeat (2) @(posedge CORE_CLK);
      RST_N <= 1'b1;
      step(1);
      chk({UPPER_PORT_LINES_OE_N, LOWER_PORT_LINES_OE_N}, 8'hFF);
      close_out;
   end
endmodule
